// ==== core_seq_model.sv ====
// Purpose: Behavioural core sequencer that takes accepted events and returns from them
// Assumes: One accept per cycle; returns are issued innermost level first
// Notes:   i_slow stretches each handler so nesting and re-latching can be seen
`default_nettype none
module core_seq_model (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_arst_n,
    // From the controller
    input  wire logic       i_accept,
    input  wire logic [3:0] i_accept_level,
    // Test controls
    input  wire logic       i_stall,
    input  wire logic       i_slow,
    // To the controller
    output logic            o_core_ready,
    output logic            o_ret,
    output logic [3:0]      o_ret_level
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] stack_q [16];
    logic [4:0] sp_q;
    logic [5:0] wait_q;

    // Ready drops only while the bench stalls the pipeline
    assign o_core_ready = !i_stall;

    // Handlers nest as a stack; only the innermost may return, which keeps pending consistent
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sp_q        <= 5'h00;
            wait_q      <= 6'h00;
            o_ret       <= 1'b0;
            o_ret_level <= 4'h0;
        end else begin
            o_ret <= 1'b0;
            if (i_accept) begin
                stack_q[sp_q[3:0]] <= i_accept_level;
                sp_q               <= sp_q + 5'h01;
                wait_q             <= i_slow ? 6'h28 : 6'h03;
            end else if (sp_q != 5'h00) begin
                if (wait_q != 6'h00) begin
                    wait_q <= wait_q - 6'h01;
                end else begin
                    o_ret       <= 1'b1;
                    o_ret_level <= stack_q[sp_q[3:0] - 4'h1];
                    sp_q        <= sp_q - 5'h01;
                    wait_q      <= i_slow ? 6'h28 : 6'h03;
                end
            end
        end
    end
endmodule : core_seq_model
`default_nettype wire

// ==== evt_ctrl_pkg.sv ====
// Purpose: Shared constants and types for the two-level event controller
// Assumes: 32-bit register port, byte addresses on word boundaries
// Notes:   Peripheral stage holds two 32-bit words per register kind
`default_nettype none
package evt_ctrl_pkg;
    localparam int          LVL_W      = 16;        // Core event levels
    localparam int          PER_W      = 64;        // Peripheral sources, two words
    localparam int          ADDR_W     = 8;
    localparam int          DATA_W     = 32;
    localparam int          IRQ_W      = 3;
    // Register byte addresses
    localparam logic [7:0]  A_LATCH    = 8'h00;
    localparam logic [7:0]  A_MASK     = 8'h04;
    localparam logic [7:0]  A_PEND     = 8'h08;
    localparam logic [7:0]  A_GLOBAL   = 8'h0c;
    localparam logic [7:0]  A_PMASK0   = 8'h10;
    localparam logic [7:0]  A_PMASK1   = 8'h14;
    localparam logic [7:0]  A_PSTAT0   = 8'h18;
    localparam logic [7:0]  A_PSTAT1   = 8'h1c;
    localparam logic [7:0]  A_PWAKE0   = 8'h20;
    localparam logic [7:0]  A_PWAKE1   = 8'h24;
    localparam logic [7:0]  A_ISTAT    = 8'h28;
    localparam logic [7:0]  A_ICLR     = 8'h2c;
    localparam logic [7:0]  A_IEN      = 8'h30;
    // Reset values
    localparam logic [15:0] RST_MASK   = 16'h0000;
    localparam logic [31:0] RST_PMASK  = 32'h0000_0000;
    localparam logic [31:0] RST_PWAKE  = 32'h0000_0000;
    localparam logic        RST_GIE    = 1'b0;
    // Levels below this one ignore the global enable
    localparam logic [15:0] NON_GP     = 16'h007f;
    localparam int          GP_FIRST   = 7;
    localparam int          PER_GRP    = 8;         // Sources per core level
    // Interrupt status bit positions
    localparam int          IB_ACCEPT  = 0;
    localparam int          IB_WAKE    = 1;
    localparam int          IB_DENIED  = 2;
    // Register port request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } bus_req_t;
endpackage : evt_ctrl_pkg
`default_nettype wire

// ==== tb.sv ====
// Purpose: Self-checking bench for the two-level event controller
// Assumes: Core sequencer model answers accepts; bench drives sources and registers
// Notes:   Each scenario is one task; waits are bounded
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import evt_ctrl_pkg::*;
    logic clk, arst_n, sup, gset, gclr, ready, ret, idle, acc, wake, irq, stall, slow;
    logic [3:0]  retl, accl;
    logic [15:0] pend, evt;
    logic [63:0] pirq;
    logic [31:0] rdata;
    bus_req_t    bus;
    int          error_cnt, check_count;

    two_level_event_controller dut_u (.i_clk(clk), .i_arst_n(arst_n), .i_bus(bus), .o_rdata(rdata),
        .i_supervisor(sup), .i_gie_set(gset), .i_gie_clr(gclr), .i_core_ready(ready), .i_ret(ret),
        .i_ret_level(retl), .i_idle(idle), .o_pending(pend), .o_accept(acc), .o_accept_level(accl),
        .o_wake(wake), .i_core_evt(evt), .i_periph_irq(pirq), .o_irq(irq));
    core_seq_model partner_u (.i_clk(clk), .i_arst_n(arst_n), .i_accept(acc), .i_accept_level(accl),
        .i_stall(stall), .i_slow(slow), .o_core_ready(ready), .o_ret(ret), .o_ret_level(retl));

    // Free-running 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : check

    // Register port master: one-cycle strobes, read data sampled the cycle after
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk) bus.wr <= 1'b0;
    endtask : wr

    task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
        @(posedge clk) bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk) bus.rd <= 1'b0;
        #1 check(n, e, rdata);
    endtask : rchk

    task automatic pulse(input logic [15:0] m);
        @(posedge clk) evt <= m;
        @(posedge clk) evt <= 16'h0000;
    endtask : pulse

    task automatic wait_acc(input string n, input logic [3:0] l, input int max);
        for (int i = 0; i < max; i++) begin
            @(posedge clk);
            #1;
            if (acc === 1'b1) break;
        end
        check(n, {28'h0, l}, (acc === 1'b1) ? {28'h0, accl} : 32'hdead_beef);
    endtask : wait_acc

    task automatic t_reset();
        rchk("mask rst", A_MASK, 32'h0);
        rchk("pmask rst", A_PMASK1, 32'h0);
        rchk("pwake rst", A_PWAKE0, 32'h0);
        rchk("unmapped", 8'h3c, 32'h0);
        wr(A_MASK, 32'h0000_0f00);
        @(posedge clk) gset <= 1'b1;
        @(posedge clk) gset <= 1'b0;
    endtask : t_reset

    task automatic t_latency();
        pulse(16'h0200);
        @(posedge clk) #1 check("accept early", 32'h0, acc);
        @(posedge clk) #1 check("accept", 32'h1, acc);
        check("accept lvl", 32'h9, accl);
        check("pending", 32'h0200, pend);
        rchk("latch cleared", A_LATCH, 32'h0);
    endtask : t_latency

    task automatic t_masked();
        pulse(16'h1000);
        repeat (6) @(posedge clk);
        #1 check("masked pend", 32'h0, pend[12]);
        rchk("masked latch", A_LATCH, 32'h1000);
        wr(A_LATCH, 32'h0);
        rchk("latch wr", A_LATCH, 32'h0);
        wr(A_LATCH, 32'h0200);
        rchk("latch wr unmasked", A_LATCH, 32'h0);
    endtask : t_masked

    task automatic t_super();
        wr(A_ICLR, 32'h7);
        @(posedge clk) sup <= 1'b0;
        wr(A_MASK, 32'hffff_ffff);
        rchk("mask user", A_MASK, 32'h0);
        rchk("pend user", A_PEND, 32'h0);
        @(posedge clk) sup <= 1'b1;
        rchk("mask kept", A_MASK, 32'h0f00);
        rchk("denied stat", A_ISTAT, 32'h4);
        wr(A_IEN, 32'h4);
        @(posedge clk) #1 check("irq on", 32'h1, irq);
        wr(A_ICLR, 32'h4);
        @(posedge clk) #1 check("irq off", 32'h0, irq);
        wr(A_IEN, 32'h0);
    endtask : t_super

    task automatic t_prio();
        @(posedge clk) stall <= 1'b1;
        pulse(16'h0500);
        repeat (3) @(posedge clk);
        @(posedge clk) stall <= 1'b0;
        wait_acc("prio first", 4'h8, 10);
        wait_acc("prio second", 4'ha, 40);
    endtask : t_prio

    task automatic t_gie();
        @(posedge clk) gclr <= 1'b1;
        @(posedge clk) gclr <= 1'b0;
        pulse(16'h0800);
        repeat (6) @(posedge clk);
        #1 check("gie off pend", 32'h0, pend[11]);
        rchk("gie off latch", A_LATCH, 32'h0800);
        @(posedge clk) gset <= 1'b1;
        @(posedge clk) gset <= 1'b0;
        wait_acc("gie on", 4'hb, 10);
        rchk("gie reg", A_GLOBAL, 32'h1);
    endtask : t_gie

    task automatic t_periph();
        wr(A_PMASK0, 32'h0);
        @(posedge clk) pirq <= 64'h0000_0000_0010_0000;
        rchk("pstat on", A_PSTAT0, 32'h0010_0000);
        repeat (4) @(posedge clk);
        #1 check("pmask block", 32'h0, pend[9]);
        wr(A_PMASK0, 32'h0010_0000);
        wait_acc("pmask fwd", 4'h9, 10);
        wr(A_PWAKE0, 32'h0010_0000);
        @(posedge clk) idle <= 1'b1;
        repeat (2) @(posedge clk);
        #1 check("wake", 32'h1, wake);
        @(posedge clk) idle <= 1'b0;
        pirq <= 64'h0;
        rchk("pstat off", A_PSTAT0, 32'h0);
    endtask : t_periph

    task automatic t_relatch();
        @(posedge clk) slow <= 1'b1;
        pulse(16'h0200);
        wait_acc("relatch first", 4'h9, 10);
        pulse(16'h0200);
        pulse(16'h0200);
        rchk("relatch latch", A_LATCH, 32'h0200);
        check("relatch pend", 32'h1, pend[9]);
        @(posedge clk) slow <= 1'b0;
        wait_acc("queued", 4'h9, 100);
    endtask : t_relatch

    task automatic report_and_stop();
        if (error_cnt == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop

    // Watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        #100us;
        error_cnt++;
        report_and_stop();
    end

    initial begin
        {arst_n, gset, gclr, idle, stall, slow} = 6'h0;
        sup  = 1'b1;
        bus  = '0;
        evt  = 16'h0;
        pirq = 64'h0;
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        t_reset();
        t_latency();
        t_masked();
        t_super();
        t_prio();
        t_gie();
        t_periph();
        t_relatch();
        report_and_stop();
    end
endmodule : tb
`default_nettype wire

// ==== two_level_event_controller.sv ====
// Purpose: Core event latch/mask/pending stage plus peripheral mask/status/wakeup stage
// Assumes: All inputs synchronous to i_clk; supervisor flag comes from the core
// Notes:   Peripheral source n feeds core level 7 + n/8
//
// Operation
// - Latch, mask and pending registers, sixteen bits, one per level.
// - Rising edge on an event input sets its latch bit; detection takes two clocks.
// - Latch bit clears when the matching pending bit sets.
// - After pending sets, the next rising edge on that input is latched again.
// - Pending follows an input edge by at least three clocks.
// - Hardware updates latch; software writes a latch bit only while its mask bit is zero.
// - Mask bit one: event is serviced when asserted.
// - Mask bit zero: event not serviced, though it may stay latched.
// - Mask register readable and writable only in supervisor mode.
// - Global enable and disable instructions gate all general-purpose levels.
// - One pending bit per level, set while active or nested.
// - Pending kept by hardware only; readable only in supervisor mode.
// - Peripheral mask, status and wakeup registers, two 32-bit words each.
// - Peripheral mask one forwards the source; zero blocks it.
// - Peripheral status bit reads one while that source asserts.
// - Enabled wakeup source asserting while core idles wakes the processor.
// - Simultaneous or repeated pulses on a shared level are tolerated.
// - Peripheral stage watches pending as the acknowledgement.
//
// The plain strobed port and the address map are this design's own decisions.
`default_nettype none
module two_level_event_controller
    import evt_ctrl_pkg::*;
(
    // Clock and reset
    input  wire logic                          i_clk,
    input  wire logic                          i_arst_n,
    // Register port
    input  wire evt_ctrl_pkg::bus_req_t        i_bus,
    output logic [evt_ctrl_pkg::DATA_W-1:0]    o_rdata,
    // Core side
    input  wire logic                          i_supervisor,
    input  wire logic                          i_gie_set,
    input  wire logic                          i_gie_clr,
    input  wire logic                          i_core_ready,
    input  wire logic                          i_ret,
    input  wire logic [3:0]                    i_ret_level,
    input  wire logic                          i_idle,
    output logic [evt_ctrl_pkg::LVL_W-1:0]     o_pending,
    output logic                               o_accept,
    output logic [3:0]                         o_accept_level,
    output logic                               o_wake,
    // Event sources
    input  wire logic [evt_ctrl_pkg::LVL_W-1:0] i_core_evt,
    input  wire logic [evt_ctrl_pkg::PER_W-1:0] i_periph_irq,
    // Interrupt
    output logic                               o_irq
);
    import evt_ctrl_pkg::*;

    // Index of the lowest set bit, 16 when none is set
    function automatic logic [4:0] first_set(input logic [LVL_W-1:0] v);
        logic [4:0] r;
        r = 5'h10;
        for (int i = LVL_W - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 5'(i);
            end
        end
        return r;
    endfunction : first_set

    logic [LVL_W-1:0]  latch_q, mask_q, pend_q;
    logic [LVL_W-1:0]  evt_q1, evt_q2;
    logic [PER_W-1:0]  pmask_q, pwake_q, pstat_q;
    logic              gie_q;
    logic [IRQ_W-1:0]  istat_q, ien_q;
    logic [LVL_W-1:0]  evt_in, rise_w, cand, accept_oh, ret_oh;
    logic [4:0]        lvl, floor_lvl;
    logic              take, wr_ok_mask, denied, wake_ev;
    logic [IRQ_W-1:0]  ievt;

    // Shared peripheral groups are ORed onto their level, pulses merge here
    always_comb begin
        evt_in = i_core_evt;
        for (int k = 0; k < PER_W / PER_GRP; k++) begin
            evt_in[GP_FIRST + k] = i_core_evt[GP_FIRST + k]
                | (|(i_periph_irq[k*PER_GRP +: PER_GRP] & pmask_q[k*PER_GRP +: PER_GRP]));
        end
    end

    // Two-stage edge detector on the merged inputs
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            evt_q1 <= '0;
            evt_q2 <= '0;
        end else begin
            evt_q1 <= evt_in;
            evt_q2 <= evt_q1;
        end
    end
    assign rise_w = evt_q1 & ~evt_q2;

    // Acceptance: lowest level, above every active level, masked and gated
    always_comb begin
        cand      = latch_q & mask_q & ~pend_q & (gie_q ? {LVL_W{1'b1}} : NON_GP);
        lvl       = first_set(cand);
        floor_lvl = first_set(pend_q);
        take      = i_core_ready && (lvl < floor_lvl);
        accept_oh = take ? (LVL_W'(1) << lvl[3:0]) : '0;
        ret_oh    = i_ret ? (LVL_W'(1) << i_ret_level) : '0;
    end

    // Software access to the mask and pending registers is gated by supervisor mode
    assign wr_ok_mask = i_supervisor;
    assign denied = (i_bus.wr || i_bus.rd) && !i_supervisor
                    && (i_bus.addr == A_MASK || i_bus.addr == A_PEND);

    // Latch: new edges win over the clear made by acceptance
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            latch_q <= '0;
        end else begin
            if (i_bus.wr && i_bus.addr == A_LATCH) begin
                latch_q <= (((latch_q & ~accept_oh) & mask_q)
                           | (i_bus.wdata[LVL_W-1:0] & ~mask_q)) | rise_w;
            end else begin
                latch_q <= (latch_q & ~accept_oh) | rise_w;
            end
        end
    end

    // Mask register, written only in supervisor mode
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            mask_q <= RST_MASK;
        end else if (i_bus.wr && i_bus.addr == A_MASK && wr_ok_mask) begin
            mask_q <= i_bus.wdata[LVL_W-1:0];
        end
    end

    // Pending: hardware sets on accept, return clears; no software write
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pend_q <= '0;
        end else begin
            pend_q <= (pend_q & ~ret_oh) | accept_oh;
        end
    end

    // Global enable from the two core instructions, or software
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            gie_q <= RST_GIE;
        end else if (i_gie_set) begin
            gie_q <= 1'b1;
        end else if (i_gie_clr) begin
            gie_q <= 1'b0;
        end else if (i_bus.wr && i_bus.addr == A_GLOBAL && i_supervisor) begin
            gie_q <= i_bus.wdata[0];
        end
    end

    // Peripheral mask and wakeup words
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pmask_q <= {RST_PMASK, RST_PMASK};
            pwake_q <= {RST_PWAKE, RST_PWAKE};
        end else if (i_bus.wr) begin
            case (i_bus.addr)
                A_PMASK0: pmask_q[31:0]  <= i_bus.wdata;
                A_PMASK1: pmask_q[63:32] <= i_bus.wdata;
                A_PWAKE0: pwake_q[31:0]  <= i_bus.wdata;
                A_PWAKE1: pwake_q[63:32] <= i_bus.wdata;
                default: ;
            endcase
        end
    end

    // Raw source levels, so software can find who shares a level
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pstat_q <= '0;
        end else begin
            pstat_q <= i_periph_irq;
        end
    end

    // Wakeup only matters while idle; mask does not block it
    assign wake_ev = i_idle && (|(i_periph_irq & pwake_q));
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_wake <= 1'b0;
        end else begin
            o_wake <= wake_ev;
        end
    end

    // Core handshake outputs; pending mirrors acknowledgement to the peripheral stage
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_accept       <= 1'b0;
            o_accept_level <= 4'h0;
        end else begin
            o_accept       <= take;
            o_accept_level <= lvl[3:0];
        end
    end
    assign o_pending = pend_q;

    // Block interrupt: sticky status, set wins over clear
    assign ievt = {denied, wake_ev, take};
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            istat_q <= '0;
            ien_q   <= '0;
            o_irq   <= 1'b0;
        end else begin
            if (i_bus.wr && i_bus.addr == A_ICLR) begin
                istat_q <= (istat_q & ~i_bus.wdata[IRQ_W-1:0]) | ievt;
            end else begin
                istat_q <= istat_q | ievt;
            end
            if (i_bus.wr && i_bus.addr == A_IEN) begin
                ien_q <= i_bus.wdata[IRQ_W-1:0];
            end
            o_irq <= |(istat_q & ien_q);
        end
    end

    // Read data, one cycle after the strobe; unmapped reads return zero
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rdata <= '0;
        end else if (i_bus.rd) begin
            case (i_bus.addr)
                A_LATCH:  o_rdata <= {16'h0000, latch_q};
                A_MASK:   o_rdata <= i_supervisor ? {16'h0000, mask_q} : '0;
                A_PEND:   o_rdata <= i_supervisor ? {16'h0000, pend_q} : '0;
                A_GLOBAL: o_rdata <= {31'h0000_0000, gie_q};
                A_PMASK0: o_rdata <= pmask_q[31:0];
                A_PMASK1: o_rdata <= pmask_q[63:32];
                A_PSTAT0: o_rdata <= pstat_q[31:0];
                A_PSTAT1: o_rdata <= pstat_q[63:32];
                A_PWAKE0: o_rdata <= pwake_q[31:0];
                A_PWAKE1: o_rdata <= pwake_q[63:32];
                A_ISTAT:  o_rdata <= {29'h0000_0000, istat_q};
                A_IEN:    o_rdata <= {29'h0000_0000, ien_q};
                default:  o_rdata <= '0;
            endcase
        end else begin
            o_rdata <= '0;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);

    // A detected edge must always land in the latch
    latch_set_a: assert property ((rise_w != 0) |=> ((latch_q & $past(rise_w)) == $past(rise_w)))
        else $error("edge did not set latch");

    // Acceptance moves the bit from latch to pending in one step
    latch_clear_a: assert property ((accept_oh != 0) |=>
        ((latch_q & $past(accept_oh & ~rise_w)) == 0) && ((pend_q & $past(accept_oh)) != 0))
        else $error("accept did not move latch to pending");

    // Masked levels may sit latched but never enter the pipeline
    mask_gate_a: assert property ((accept_oh & ~mask_q) == 0)
        else $error("masked level accepted");

    // Global disable holds back only the general-purpose levels
    global_gate_a: assert property (!gie_q |-> ((accept_oh & ~NON_GP) == 0))
        else $error("general level accepted while disabled");

    // User-mode writes to the mask are dropped
    mask_protect_a: assert property ((i_bus.wr && i_bus.addr == A_MASK && !i_supervisor) |=> $stable(mask_q))
        else $error("mask changed outside supervisor");

    // User-mode pending reads return zero
    pend_read_a: assert property ((i_bus.rd && i_bus.addr == A_PEND && !i_supervisor) |=> (o_rdata == 0))
        else $error("pending visible outside supervisor");

    // A new pending bit needs a latched bit one cycle before it
    pend_latency_a: assert property (((pend_q & ~$past(pend_q)) & ~$past(latch_q)) == 0)
        else $error("pending set without prior latch");

    // No lower candidate may be skipped
    lowest_first_a: assert property (take |-> ((cand & ((LVL_W'(1) << lvl[3:0]) - LVL_W'(1))) == 0))
        else $error("higher level accepted before lower");

    // Status word reads back what was captured from the sources
    status_read_a: assert property ((i_bus.rd && i_bus.addr == A_PSTAT0) |=> (o_rdata == $past(pstat_q[31:0])))
        else $error("status read mismatch");

    // An enabled source while idle must raise wake next cycle
    wake_out_a: assert property ((i_idle && (|(i_periph_irq & pwake_q))) |=> o_wake)
        else $error("wakeup missed");

    // The registered accept carries the level chosen a cycle earlier
    accept_out_a: assert property (take |=> (o_accept && (o_accept_level == $past(lvl[3:0]))))
        else $error("accept output wrong");

    // A stalled core takes nothing, which is how latency grows
    accept_ready_a: assert property (!i_core_ready |-> !take)
        else $error("accept while core not ready");

    // Nesting only goes deeper, never sideways
    nest_order_a: assert property (take |-> (lvl < floor_lvl))
        else $error("accept not above active level");

    // A return clears exactly the level it names
    pend_clear_a: assert property ((ret_oh != 0) |=> ((pend_q & $past(ret_oh & ~accept_oh)) == 0))
        else $error("return did not clear pending");

    // Only accept and return move pending; bus writes cannot
    pend_hold_a: assert property ((!i_ret && !take) |=> (pend_q == $past(pend_q)))
        else $error("pending changed without hardware cause");

    // An edge on an already pending level is queued again
    relatch_a: assert property (((rise_w & pend_q) != 0) |=> ((latch_q & $past(rise_w & pend_q)) != 0))
        else $error("edge on pending level lost");

    // Software cannot touch latch bits whose mask bit is one
    latch_sw_a: assert property ((i_bus.wr && i_bus.addr == A_LATCH) |=>
        (((latch_q ^ $past(latch_q)) & $past(mask_q & ~rise_w & ~accept_oh)) == 0))
        else $error("unmasked latch bit written");

    // Without edge, accept or write the latch stays put
    latch_only_a: assert property ((rise_w == 0 && accept_oh == 0 && !(i_bus.wr && i_bus.addr == A_LATCH))
        |=> $stable(latch_q))
        else $error("latch changed without cause");

    // An unmasked, enabled event with nothing active is served at once
    serve_a: assert property (((cand != 0) && (pend_q == 0) && i_core_ready) |-> take)
        else $error("unmasked event not served");

    // The chosen level is a real candidate
    first_level_a: assert property (take |-> cand[lvl[3:0]])
        else $error("accepted level not a candidate");

    // Enable instruction turns the global gate on
    gie_set_a: assert property (i_gie_set |=> gie_q)
        else $error("global enable ignored");

    // Disable instruction turns it off unless enable comes too
    gie_clr_a: assert property ((i_gie_clr && !i_gie_set) |=> !gie_q)
        else $error("global disable ignored");

    // Status follows the raw sources one cycle later
    pstat_follow_a: assert property ((i_periph_irq != 0) |=> (pstat_q == $past(i_periph_irq)))
        else $error("source status lagging");

    // With every peripheral masked the merged inputs are the core inputs
    pmask_block_a: assert property ((pmask_q == 0) |-> (evt_in == i_core_evt))
        else $error("masked peripheral forwarded");

    // Wake never rises while the core runs
    wake_idle_a: assert property (!i_idle |=> !o_wake)
        else $error("wake while not idle");

    // Read data stands only in the cycle after a read
    rdata_idle_a: assert property (!i_bus.rd |=> (o_rdata == 0))
        else $error("read data outside read cycle");

    // Supervisor writes land in the mask
    mask_write_a: assert property ((i_bus.wr && i_bus.addr == A_MASK && i_supervisor)
        |=> (mask_q == $past(i_bus.wdata[LVL_W-1:0])))
        else $error("supervisor mask write lost");

    // User-mode mask reads return zero
    mask_read_a: assert property ((i_bus.rd && i_bus.addr == A_MASK && !i_supervisor) |=> (o_rdata == 0))
        else $error("mask visible outside supervisor");

    // Supervisor pending reads show the register
    pend_read_ok_a: assert property ((i_bus.rd && i_bus.addr == A_PEND && i_supervisor)
        |=> (o_rdata[LVL_W-1:0] == $past(pend_q)))
        else $error("pending read mismatch");
endmodule : two_level_event_controller
`default_nettype wire
